// >>> rtl/fds_consts.svh
// Constants for the fabric discovery sequencer
`ifndef FDS_CONSTS_SVH
`define FDS_CONSTS_SVH

// Register map of the local command port
`define FDS_REG_CTRL        8'h00
`define FDS_REG_IDENT       8'h04
`define FDS_REG_STATUS      8'h08
`define FDS_REG_PORTS       8'h0C
`define FDS_CTRL_START_BIT  0
`define FDS_CTRL_ID_LSB     8
`define FDS_HOST_ID_RST     8'h01
`define FDS_IDENT_RST       32'h0000_0000

// Maintenance offsets in the far devices
`define FDS_OFF_IDENT       24'h00_0000
`define FDS_OFF_PORT_INFO   24'h00_0014
`define FDS_OFF_BASE_ID     24'h00_0060
`define FDS_OFF_HOST_LOCK   24'h00_0068
`define FDS_PORT_REGION0    24'h01_0000
`define FDS_PORT_SHIFT      17
`define FDS_OFF_TRAIN       24'h00_0068
`define FDS_OFF_ROUTE_0_7   24'h00_0A00
`define FDS_OFF_ROUTE_F8    24'h01_0A7C

// Transaction attributes and field values
`define FDS_HOP_SWITCH      8'h00
`define FDS_HOP_BEYOND      8'hFF
`define FDS_ID_UNDISC       8'hFF
`define FDS_LOCK_FREE       16'hFFFF
`define FDS_ROUTE_0_7       32'h8883_2108
`define FDS_ROUTE_F8_REST   28'h888_8888
`define FDS_TRAINED_BIT     0
`define FDS_BASE_ID_LSB     16

// Outbound target word layout
`define FDS_TGT_ID_LSB      22
`define FDS_TGT_HOP_LSB     12
`define FDS_TGT_OFF_LSB     0

`endif

// >>> rtl/fds_pkg.sv
// Types shared by the fabric discovery sequencer
package fds_pkg;

    typedef struct packed {
        logic        write;
        logic [7:0]  dest;
        logic [7:0]  hop;
        logic [23:0] offset;
        logic [31:0] wdata;
    } maint_req_t;

    typedef struct packed {
        logic        valid;
        logic        error;
        logic [31:0] data;
    } maint_rsp_t;

    typedef enum logic [3:0] {
        PC_IDLE      = 4'h0,
        PC_OK        = 4'h1,
        PC_UNTRAINED = 4'h2,
        PC_LOCKED    = 4'h3,
        PC_UNKNOWN   = 4'h4,
        PC_MISMATCH  = 4'h5,
        PC_RSP_ERR   = 4'h6,
        PC_HOST      = 4'h7
    } port_code_t;

endpackage

// >>> rtl/target_word_pack.sv
// Packs a maintenance request into the outbound target word
`timescale 1ns/10ps
`include "fds_consts.svh"

module target_word_pack (
    input  fds_pkg::maint_req_t i_req,
    output logic [31:0]         o_word
);
    // Only the upper offset bits travel in the window word
    wire [11:0] upper_offset = i_req.offset[23:12];

    assign o_word = (32'(i_req.dest) << `FDS_TGT_ID_LSB)
                  | (32'(i_req.hop) << `FDS_TGT_HOP_LSB)
                  | (32'(upper_offset) << `FDS_TGT_OFF_LSB);
endmodule // target_word_pack

// >>> rtl/fabric_discovery_sequencer.sv
// Functional notes
// - Read switch port information at 0x14; switch answers host's port.
// - Read host lock at 0x68 first; undiscovered device shows 0xFFFF.
// - Switch keeps per-port 256-entry tables, one nibble per ID.
// - Nibble 0x8 marks an ID unrouted; switch flags such packets.
// - Target word: ID bits 22-29, hop 12-19, upper offset 0-11.
`timescale 1ns/10ps
`include "fds_consts.svh"

module fabric_discovery_sequencer #(
    parameter int NUM_PORTS = 4
) (
    input  wire logic               i_clock,
    input  wire logic               i_resetn,
    input  wire logic [7:0]         i_addr,
    input  wire logic [31:0]        i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    output logic [31:0]             o_rdata,
    output fds_pkg::maint_req_t     o_req,
    output logic                    o_req_valid,
    output logic [31:0]             o_target_word,
    input  fds_pkg::maint_rsp_t     i_rsp
);
    localparam int PW = $clog2(NUM_PORTS);

    // Port count limited by the four switch register regions
    if (NUM_PORTS < 2 || NUM_PORTS > 4) begin : g_bad_ports
        $error("NUM_PORTS must lie between 2 and 4");
    end

    typedef enum logic [14:0] {
        S_IDLE   = 15'h0001,
        S_PINFO  = 15'h0002,
        S_SWL_RD = 15'h0004,
        S_SWL_WR = 15'h0008,
        S_SWL_CK = 15'h0010,
        S_ROUTE  = 15'h0020,
        S_PSEL   = 15'h0040,
        S_TRAIN  = 15'h0080,
        S_RT_FF  = 15'h0100,
        S_IDENT  = 15'h0200,
        S_LK_RD  = 15'h0400,
        S_LK_WR  = 15'h0800,
        S_LK_CK  = 15'h1000,
        S_DID    = 15'h2000,
        S_DID_CK = 15'h4000
    } state_t;

    function automatic logic [23:0] port_region(input logic [PW-1:0] p);
        port_region = `FDS_PORT_REGION0 + (24'(p) << `FDS_PORT_SHIFT);
    endfunction

    function automatic logic [7:0] port_id(input logic [PW-1:0] p);
        port_id = 8'(p) + `FDS_HOST_ID_RST;
    endfunction

    // Reset release through two flops
    logic rst_meta_r;
    logic rst_sync_r;
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    wire resetn = rst_sync_r;

    state_t                state_r;
    state_t                state_nxt;
    logic                  pend_r;
    logic [PW-1:0]         port_r;
    logic [PW-1:0]         port_nxt;
    logic [PW-1:0]         host_port_r;
    logic [7:0]            host_id_r;
    logic [31:0]           ident_r;
    logic                  busy_r;
    logic                  done_r;
    logic                  sw_fail_r;
    fds_pkg::port_code_t   code_r [NUM_PORTS];
    fds_pkg::maint_req_t   req;
    logic [31:0]           word;

    // Register decode
    wire sel_ctrl   = i_addr == `FDS_REG_CTRL;
    wire sel_ident  = i_addr == `FDS_REG_IDENT;
    wire sel_status = i_addr == `FDS_REG_STATUS;
    wire sel_ports  = i_addr == `FDS_REG_PORTS;
    wire start = i_wr && sel_ctrl && i_wdata[`FDS_CTRL_START_BIT] && !busy_r;

    logic [31:0] ports_word;
    always_comb begin
        ports_word = 32'h0000_0000;
        for (int i = 0; i < NUM_PORTS; i++) begin
            ports_word[4*i +: 4] = code_r[i];
        end
    end
    wire [31:0] status_word = {16'h0000, 8'(host_port_r),
                               5'h00, sw_fail_r, done_r, busy_r};
    wire [31:0] rd_mux = sel_ctrl   ? 32'(host_id_r) << `FDS_CTRL_ID_LSB :
                         sel_ident  ? ident_r :
                         sel_status ? status_word :
                         sel_ports  ? ports_word : 32'h0000_0000;

    // Response evaluation
    wire        rsp_here  = pend_r && i_rsp.valid;
    wire        rsp_err   = i_rsp.error;
    wire [15:0] lock_val  = i_rsp.data[15:0];
    wire        lock_free = lock_val == `FDS_LOCK_FREE;
    wire        lock_mine = lock_val == 16'(host_id_r);
    wire        trained   = i_rsp.data[`FDS_TRAINED_BIT];
    wire        known     = i_rsp.data == ident_r;
    wire        id_back   = i_rsp.data[`FDS_BASE_ID_LSB +: 8]
                            == port_id(port_r);
    wire        last_port = port_r == PW'(NUM_PORTS - 1);
    wire        agent     = state_r inside {S_IDENT, S_LK_RD, S_LK_WR,
                                            S_LK_CK, S_DID, S_DID_CK};

    // Request built from the current step
    always_comb begin
        req = '{write: 1'b0, dest: `FDS_ID_UNDISC, hop: `FDS_HOP_SWITCH,
                offset: `FDS_OFF_HOST_LOCK, wdata: 32'h0000_0000};
        unique case (state_r)
            S_PINFO:  req.offset = `FDS_OFF_PORT_INFO;
            S_SWL_WR, S_LK_WR: begin
                req.write = 1'b1;
                req.wdata = 32'(host_id_r);
            end
            S_ROUTE: begin
                req.write  = 1'b1;
                req.offset = port_region(port_r) + `FDS_OFF_ROUTE_0_7;
                req.wdata  = `FDS_ROUTE_0_7;
            end
            S_TRAIN:
                req.offset = port_region(port_r) + `FDS_OFF_TRAIN;
            S_RT_FF: begin
                req.write  = 1'b1;
                req.offset = `FDS_OFF_ROUTE_F8;
                req.wdata  = {4'(port_r), `FDS_ROUTE_F8_REST};
            end
            S_DID: begin
                req.write  = 1'b1;
                req.offset = `FDS_OFF_BASE_ID;
                req.wdata  = 32'(port_id(port_r)) << `FDS_BASE_ID_LSB;
            end
            S_DID_CK: begin
                req.dest   = port_id(port_r);
                req.offset = `FDS_OFF_BASE_ID;
            end
            S_IDENT:  req.offset = `FDS_OFF_IDENT;
            default: ;
        endcase
        if (agent) begin
            req.hop = `FDS_HOP_BEYOND;
        end
    end

    target_word_pack u_pack (
        .i_req  (req),
        .o_word (word)
    );

    // Step sequencing; each step but S_IDLE and S_PSEL waits for its response
    logic                set_code;
    fds_pkg::port_code_t code_val;
    always_comb begin
        state_nxt = state_r;
        port_nxt  = port_r;
        set_code  = 1'b0;
        code_val  = fds_pkg::PC_OK;
        unique case (state_r)
            S_IDLE:   if (start) state_nxt = S_PINFO;
            S_PSEL: begin
                if (port_r == host_port_r) begin
                    set_code = 1'b1;
                    code_val = fds_pkg::PC_HOST;
                    if (last_port) state_nxt = S_IDLE;
                    else port_nxt = port_r + PW'(1);
                end else begin
                    state_nxt = S_TRAIN;
                end
            end
            default: begin
                if (rsp_here) begin
                    unique case (state_r)
                        S_PINFO:  state_nxt = S_SWL_RD;
                        S_SWL_RD: state_nxt = lock_free ? S_SWL_WR : S_IDLE;
                        S_SWL_WR: state_nxt = S_SWL_CK;
                        S_SWL_CK: state_nxt = lock_mine ? S_ROUTE : S_IDLE;
                        S_ROUTE: begin
                            port_nxt = last_port ? '0 : port_r + PW'(1);
                            if (last_port) state_nxt = S_PSEL;
                        end
                        S_TRAIN: begin
                            state_nxt = trained ? S_RT_FF : S_PSEL;
                            set_code  = !trained;
                            code_val  = fds_pkg::PC_UNTRAINED;
                        end
                        S_RT_FF:  state_nxt = S_IDENT;
                        S_IDENT: begin
                            state_nxt = known ? S_LK_RD : S_PSEL;
                            set_code  = !known;
                            code_val  = fds_pkg::PC_UNKNOWN;
                        end
                        S_LK_RD: begin
                            state_nxt = lock_free ? S_LK_WR : S_PSEL;
                            set_code  = !lock_free;
                            code_val  = fds_pkg::PC_LOCKED;
                        end
                        S_LK_WR:  state_nxt = S_LK_CK;
                        S_LK_CK: begin
                            state_nxt = lock_mine ? S_DID : S_PSEL;
                            set_code  = !lock_mine;
                            code_val  = fds_pkg::PC_LOCKED;
                        end
                        S_DID:    state_nxt = S_DID_CK;
                        S_DID_CK: begin
                            state_nxt = S_PSEL;
                            set_code  = 1'b1;
                            code_val  = id_back ? fds_pkg::PC_OK
                                                : fds_pkg::PC_MISMATCH;
                        end
                        default: state_nxt = S_IDLE;
                    endcase
                    if (rsp_err && agent) begin
                        state_nxt = S_PSEL;
                        set_code  = 1'b1;
                        code_val  = fds_pkg::PC_RSP_ERR;
                    end else if (rsp_err && state_r != S_TRAIN
                                 && state_r != S_RT_FF) begin
                        state_nxt = S_IDLE;
                    end
                    // Leaving a probed port moves on to the next one
                    if (state_nxt == S_PSEL && state_r != S_ROUTE) begin
                        if (last_port) state_nxt = S_IDLE;
                        else port_nxt = port_r + PW'(1);
                    end
                end
            end
        endcase
    end

    wire leave  = busy_r && state_nxt == S_IDLE;
    wire sw_bad = leave && state_r != S_PSEL && !agent && state_r != S_DID_CK
                  && state_r != S_TRAIN && state_r != S_RT_FF;

    always_ff @(posedge i_clock or negedge resetn) begin
        if (!resetn) begin
            state_r     <= S_IDLE;
            pend_r      <= 1'b0;
            port_r      <= '0;
            host_port_r <= '0;
            host_id_r   <= `FDS_HOST_ID_RST;
            ident_r     <= `FDS_IDENT_RST;
            busy_r      <= 1'b0;
            done_r      <= 1'b0;
            sw_fail_r   <= 1'b0;
            o_rdata     <= 32'h0000_0000;
            o_req       <= '0;
            o_req_valid <= 1'b0;
            o_target_word <= 32'h0000_0000;
            for (int i = 0; i < NUM_PORTS; i++) code_r[i] <= fds_pkg::PC_IDLE;
        end else begin
            state_r     <= state_nxt;
            port_r      <= port_nxt;
            o_rdata     <= i_rd ? rd_mux : 32'h0000_0000;
            o_req_valid <= 1'b0;
            if (state_r != S_IDLE && state_r != S_PSEL && !pend_r) begin
                pend_r        <= 1'b1;
                o_req_valid   <= 1'b1;
                o_req         <= req;
                o_target_word <= word;
            end else if (rsp_here) begin
                pend_r <= 1'b0;
            end
            if (rsp_here && state_r == S_PINFO) begin
                host_port_r <= i_rsp.data[PW-1:0];
            end
            if (i_wr && sel_ctrl && !busy_r) begin
                host_id_r <= i_wdata[`FDS_CTRL_ID_LSB +: 8];
            end
            if (i_wr && sel_ident && !busy_r) ident_r <= i_wdata;
            if (set_code) code_r[port_r] <= code_val;
            if (start) begin
                busy_r    <= 1'b1;
                done_r    <= 1'b0;
                sw_fail_r <= 1'b0;
                port_r    <= '0;
                for (int i = 0; i < NUM_PORTS; i++) begin
                    code_r[i] <= fds_pkg::PC_IDLE;
                end
            end else if (leave) begin
                busy_r    <= 1'b0;
                done_r    <= 1'b1;
                sw_fail_r <= sw_bad;
            end
        end
    end
endmodule // fabric_discovery_sequencer

// >>> testbench/fabric_model.sv
// Behavioural switch with one agent processor behind each port
`timescale 1ns/10ps

module fabric_model #(
    parameter logic [31:0] IDENT_WORD = 32'h0A5C_3E71 // Arbitrary value
) (
    input  wire logic           i_clock,
    input  wire logic           i_resetn,
    input  fds_pkg::maint_req_t i_req,
    input  wire logic           i_req_valid,
    input  wire logic [31:0]    i_cfg,
    output fds_pkg::maint_rsp_t o_rsp
);
    // Setup: [1:0] host port, [7:4] trained, [11:8] lock refused,
    // [15:12] bad identity, [19:16] bad base id, [23:20] error,
    // [24] switch taken, [31:28] answer delay
    fds_pkg::maint_req_t q;
    logic [15:0]         sw_lock;
    logic [15:0]         lock [4];
    logic [7:0]          bid [4];
    logic [31:0]         rt07;
    logic [31:0]         rtff;
    logic [31:0]         rd;
    logic                er;
    logic                pend;
    logic [3:0]          cnt;
    logic [3:0]          rt_seen;
    wire  [3:0]          np = (q.dest == 8'hFF) ? rtff[31:28]
                                : rt07[{q.dest[2:0], 2'b00} +: 4];
    wire  [1:0]          p  = np[1:0];
    wire                 sw = (q.hop == 8'h00);

    always_comb begin
        rd = 32'h0;
        er = 1'b0;
        if (sw) begin // Destination ignored
            if (q.offset == 24'h00_0014)
                rd = {30'h0, i_cfg[1:0]};
            else if (q.offset == 24'h00_0068)
                rd = {16'h0, sw_lock};
            else if (q.offset[16:0] == 17'h1_0068)
                rd = {31'h0, i_cfg[4 + q.offset[18:17]]};
        end else begin
            er = np[3] | i_cfg[20 + p];
            if (q.offset == 24'h00_0000)
                rd = i_cfg[12 + p] ? ~IDENT_WORD : IDENT_WORD;
            else if (q.offset == 24'h00_0068)
                rd = {16'h0, lock[p]};
            else if (q.offset == 24'h00_0060)
                rd = {8'h0, bid[p] ^ {7'h0, i_cfg[16 + p]}, 16'h0};
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rsp   <= '0;
            pend    <= 1'b0;
            cnt     <= 4'h0;
            rt_seen <= 4'h0;
            q       <= '0;
            sw_lock <= i_cfg[24] ? 16'h0009 : 16'hFFFF;
            rt07    <= 32'h8888_8888;
            rtff    <= 32'h8888_8888;
            lock    <= '{default: 16'hFFFF};
            bid     <= '{default: 8'hFF};
        end else begin
            o_rsp.valid <= 1'b0;
            o_rsp.error <= 1'b0;
            o_rsp.data  <= ~o_rsp.data; // Data inverted every cycle between answers
            if (i_req_valid) begin
                q    <= i_req;
                pend <= 1'b1;
                cnt  <= i_cfg[31:28];
            end else if (pend && cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else if (pend) begin
                pend        <= 1'b0;
                o_rsp.valid <= 1'b1;
                o_rsp.error <= er;
                o_rsp.data  <= rd;
                if (q.write && sw && q.offset == 24'h68 &&
                    sw_lock == 16'hFFFF)
                    sw_lock <= q.wdata[15:0];
                if (q.write && q.offset == 24'h01_0A00)
                    rt07 <= q.wdata; // Host enters on port 0
                if (q.write && q.offset == 24'h01_0A7C)
                    rtff <= q.wdata;
                // One flag per port table written at its 0x0A00 entry
                if (q.write && sw && q.offset[16:0] == 17'h1_0A00)
                    rt_seen[q.offset[18:17]] <= 1'b1;
                if (q.write && !sw && !er && q.offset == 24'h68 &&
                    lock[p] == 16'hFFFF && !i_cfg[8 + p])
                    lock[p] <= q.wdata[15:0];
                if (q.write && !sw && !er && q.offset == 24'h60)
                    bid[p] <= q.wdata[23:16];
            end
        end
    end
endmodule // fabric_model

// >>> testbench/fabric_discovery_sequencer_chk.sv
// Port checker for the discovery sequencer
`timescale 1ns/10ps

module fabric_discovery_sequencer_chk #(
    parameter int NUM_PORTS = 4
) (
    input wire logic          i_clock,
    input wire logic          i_resetn,
    input wire logic [7:0]    i_addr,
    input wire logic [31:0]   i_wdata,
    input wire logic          i_wr,
    input wire logic          i_rd,
    input wire logic [31:0]   o_rdata,
    input fds_pkg::maint_req_t o_req,
    input wire logic          o_req_valid,
    input wire logic [31:0]   o_target_word,
    input fds_pkg::maint_rsp_t i_rsp
);
    logic       pend_r;
    logic       after_rt_r;
    logic [7:0] hid_r;
    wire        wr_q = o_req_valid && o_req.write;

    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            pend_r     <= 1'b0;
            after_rt_r <= 1'b0;
            hid_r      <= 8'h01;
        end else begin
            if (o_req_valid)
                pend_r <= 1'b1;
            else if (i_rsp.valid)
                pend_r <= 1'b0;
            if (o_req_valid)
                after_rt_r <= wr_q && o_req.offset == 24'h01_0A7C;
            if (i_wr && i_addr == 8'h00)
                hid_r <= i_wdata[15:8];
        end
    end

    one_pending_a: assert property (o_req_valid |-> !pend_r)
        else $error("request issued before answer");
    req_hold_a: assert property (pend_r && !o_req_valid |->
        $stable(o_req) && $stable(o_target_word))
        else $error("request changed while pending");
    hop_kind_a: assert property (o_req_valid |->
        o_req.hop == 8'h00 || o_req.hop == 8'hFF)
        else $error("bad hop count");
    target_word_a: assert property (o_req_valid |-> o_target_word ==
        {2'b00, o_req.dest, 2'b00, o_req.hop, o_req.offset[23:12]})
        else $error("target word wrong");
    agent_dest_a: assert property (o_req_valid && o_req.hop == 8'hFF &&
        o_req.dest != 8'hFF |-> !o_req.write && o_req.offset == 24'h60)
        else $error("assigned id used wrongly");
    lock_data_a: assert property (wr_q && o_req.offset == 24'h68 |->
        o_req.wdata[7:0] == hid_r)
        else $error("lock write not own id");
    route_entry_a: assert property (wr_q && o_req.offset[15:0] == 16'h0A00
        |-> o_req.wdata == 32'h8883_2108 && o_req.hop == 8'h00)
        else $error("route entry wrong");
    route_ff_a: assert property (wr_q && o_req.offset == 24'h01_0A7C |->
        o_req.wdata[27:0] == 28'h888_8888 && o_req.wdata[31:30] == 2'b00)
        else $error("route entry for ff wrong");
    ident_first_a: assert property (o_req_valid && after_rt_r |->
        !o_req.write && o_req.offset == 24'h0 && o_req.dest == 8'hFF)
        else $error("identity not read first");
    base_id_a: assert property (wr_q && o_req.offset == 24'h60 |->
        o_req.hop == 8'hFF && o_req.wdata[23:16] inside {8'h02, 8'h03, 8'h04})
        else $error("base id write wrong");
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside its cycle");
endmodule // fabric_discovery_sequencer_chk

bind fabric_discovery_sequencer fabric_discovery_sequencer_chk #(
    .NUM_PORTS(NUM_PORTS)
) u_chk (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_req(o_req),
    .o_req_valid(o_req_valid),
    .o_target_word(o_target_word),
    .i_rsp(i_rsp)
);

// >>> testbench/fabric_discovery_sequencer_tb.sv
// Self-checking bench for the discovery sequencer
`timescale 1ns/10ps

module fabric_discovery_sequencer_tb;
    localparam logic [31:0] IDW = 32'h0A5C_3E71; // Arbitrary identity
    logic                i_clock;
    logic                i_resetn;
    logic [7:0]          i_addr;
    logic [31:0]         i_wdata;
    logic                i_wr;
    logic                i_rd;
    logic [31:0]         o_rdata;
    fds_pkg::maint_req_t o_req;
    logic                o_req_valid;
    logic [31:0]         o_target_word;
    fds_pkg::maint_rsp_t i_rsp;
    logic [31:0]         cfg;
    logic [31:0]         v;
    logic [7:0]          a;
    int                  n;
    int                  mismatches;
    int                  cmp_count;
    // Per test: far side setup, host id, port codes, status
    logic [31:0] cfgs [3] = '{32'h0084_00F0, 32'h5000_18D2, 32'h0100_00F0};
    logic [7:0]  hids [3] = '{8'h01, 8'h05, 8'h01};
    logic [31:0] eprt [3] = '{32'h0000_6517, 32'h0000_3724, 32'h0};
    logic [31:0] ests [3] = '{32'h0000_0002, 32'h0000_0202, 32'h0000_0006};

    always #10 i_clock = ~i_clock;

    fabric_discovery_sequencer #(.NUM_PORTS(4)) u_dut (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .o_req(o_req),
        .o_req_valid(o_req_valid),
        .o_target_word(o_target_word),
        .i_rsp(i_rsp)
    );

    fabric_model #(.IDENT_WORD(IDW)) u_model (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_req(o_req),
        .i_req_valid(o_req_valid),
        .i_cfg(cfg),
        .o_rsp(i_rsp)
    );

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge i_clock);
        i_addr  <= ad;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clock);
        i_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad, output logic [31:0] d);
        @(posedge i_clock);
        i_addr <= ad;
        i_rd   <= 1'b1;
        @(posedge i_clock);
        i_rd   <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        i_clock  = 1'b0;
        i_resetn = 1'b0;
        i_addr   = 8'h00;
        i_wdata  = 32'h0;
        i_wr     = 1'b0;
        i_rd     = 1'b0;
        cfg      = 32'h0;
        for (int k = 0; k < 3; k++) begin
            cfg = cfgs[k];
            i_resetn <= 1'b0;
            repeat (10) @(posedge i_clock);
            i_resetn <= 1'b1;
            repeat (3) @(posedge i_clock);
            if (k == 0) begin
                rd(8'h00, v);
                chk({24'h0, v[15:8]}, 32'h1);
                // Identity, status, ports and one unmapped place
                for (a = 8'h04; a <= 8'h10; a += 8'h04) begin
                    rd(a, v);
                    chk(v, 32'h0);
                end
            end
            wr(8'h04, IDW);
            wr(8'h00, {16'h0, hids[k], 8'h01});
            v = 32'h0;
            for (n = 0; n < 3000 && v[1] !== 1'b1; n++)
                rd(8'h08, v);
            if (v[1] !== 1'b1) begin
                mismatches++;
                tally_and_finish();
            end
            chk(v, ests[k]);
            rd(8'h0C, v);
            chk(v, eprt[k]);
            chk({28'h0, u_model.rt_seen}, k == 2 ? 32'h0 : 32'hF);
            if (k == 0) begin
                chk(u_model.rt07, 32'h8883_2108);
                chk(u_model.rtff, 32'h3888_8888);
                chk({24'h0, u_model.bid[1]}, 32'h2);
                chk({24'h0, u_model.bid[2]}, 32'h3);
            end
            $display("test %0d finished", k);
        end
        tally_and_finish();
    end
endmodule // fabric_discovery_sequencer_tb
